// *** core/sdadc_cfg.svh ***
// Purpose: offsets, field positions, reset values and counts
// Assumes: 8-bit special function register port
// Notes: definitions only
`ifndef SDADC_CFG_SVH
`define SDADC_CFG_SVH
`define SDADC_A_SETUP    8'hdc
`define SDADC_A_CAL      8'hdd
`define SDADC_A_DEC_LO   8'hde
`define SDADC_A_DEC_HI   8'hdf
`define SDADC_A_TRIM     8'he6
`define SDADC_A_DAC_LO   8'he8
`define SDADC_A_DAC_HI   8'he9
`define SDADC_A_ACLK     8'hf6
`define SDADC_B_BUF      0
`define SDADC_B_REF_EN   1
`define SDADC_B_REF_HI   2
`define SDADC_B_REF_EXT  3
`define SDADC_B_GAIN     4
`define SDADC_B_BIPOLAR  7
`define SDADC_B_FILT     3
`define SDADC_B_FLAG     7
`define SDADC_R_SETUP    8'h06
`define SDADC_R_ACLK     8'h03
`define SDADC_R_DEC      16'h0100
`define SDADC_MOD_DIV    64
`define SDADC_CAL_STEP   7
`define SDADC_FAST_CONV  2
`endif

// *** core/sdadc_pkg.sv ***
// Purpose: shared types of the converter control
// Assumes: nothing
// Notes: state structs, one per module
package sdadc_pkg;
	typedef enum logic [1:0] {SDADC_F_AUTO, SDADC_F_FAST, SDADC_F_SINC2, SDADC_F_SINC3} sdadc_filt_t;
	typedef enum logic [1:0] {SDADC_CAL_IDLE, SDADC_CAL_OFFSET, SDADC_CAL_GAIN} sdadc_cal_t;
	typedef struct packed {
		logic [7:0] aclk_cnt;
		logic [5:0] mod_cnt;
		logic       mod_tick;
	} sdadc_div_t;
	typedef struct packed {
		logic        sync1;
		logic        sync2;
		logic [15:0] cnt;
		logic [15:0] ones;
		logic [1:0]  since;
		logic        ready;
		logic [15:0] word;
		sdadc_filt_t filt;
		logic        discard;
	} sdadc_dec_t;
	typedef struct packed {
		logic [7:0]  setup;
		logic [2:0]  sel;
		sdadc_filt_t mode;
		logic        flag;
		logic [15:0] dec;
		logic [7:0]  trim;
		logic [7:0]  aclk;
		logic [7:0]  dac_lo;
		logic [15:0] dac;
		logic        dac_load;
		logic [7:0]  rdata;
		sdadc_cal_t  cal;
		logic        cal_both;
		logic        cal_sys;
		logic [2:0]  cal_cnt;
		logic        restart;
		logic        tick;
		logic        ready;
		logic [15:0] word;
		sdadc_filt_t filt;
		logic        discard;
		logic [7:0]  gain;
	} sdadc_top_t;
endpackage

// *** core/sdadc_link_if.sv ***
// Purpose: carrier between control, divider and decimator
// Assumes: one clock
// Notes: top drives the control side directly
`timescale 1ns/1ps
interface sdadc_link_if;
	logic [7:0]            divisor;
	logic                  mod_tick;
	logic [15:0]           ratio;
	sdadc_pkg::sdadc_filt_t mode;
	logic                  restart;
	logic                  mod_bit;
	logic                  ready;
	logic [15:0]           word;
	sdadc_pkg::sdadc_filt_t filt;
	logic                  discard;
	modport div_side (input divisor, output mod_tick);
	modport dec_side (input mod_tick, ratio, mode, restart, mod_bit,
		output ready, word, filt, discard);
endinterface

// *** core/sdadc_clkdiv.sv ***
// Purpose: analog clock and modulator clock tick generation
// Assumes: synchronised reset
// Notes: tick period is (divisor + 1) * 64 system clocks
`timescale 1ns/1ps
`include "sdadc_cfg.svh"
module sdadc_clkdiv (
	input  wire logic clock,
	input  wire logic rst_n,
	sdadc_link_if.div_side lk
);
	sdadc_pkg::sdadc_div_t s;
	sdadc_pkg::sdadc_div_t next_s;

	// [R2] divide by n plus one, then 64
	always_comb begin
		next_s = s;
		next_s.mod_tick = 1'b0;
		if (s.aclk_cnt >= lk.divisor) begin
			next_s.aclk_cnt = 8'h00;
			if (s.mod_cnt == 6'(`SDADC_MOD_DIV - 1)) begin
				next_s.mod_cnt = 6'h00;
				next_s.mod_tick = 1'b1;
			end else begin
				next_s.mod_cnt = s.mod_cnt + 6'h01;
			end
		end else begin
			next_s.aclk_cnt = s.aclk_cnt + 8'h01;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign lk.mod_tick = s.mod_tick;
endmodule

// *** core/sdadc_decim.sv ***
// Purpose: decimation period counter and filter sequencing
// Assumes: modulator bit is asynchronous
// Notes: word is the ones count over one period
`timescale 1ns/1ps
`include "sdadc_cfg.svh"
module sdadc_decim (
	input  wire logic clock,
	input  wire logic rst_n,
	sdadc_link_if.dec_side lk
);
	sdadc_pkg::sdadc_dec_t s;
	sdadc_pkg::sdadc_dec_t next_s;
	logic [15:0]           last;

	always_comb begin
		next_s = s;
		next_s.sync1 = lk.mod_bit;
		next_s.sync2 = s.sync1;
		next_s.ready = 1'b0;
		last = (lk.ratio == 16'h0000) ? 16'h0000 : lk.ratio - 16'h0001;
		if (lk.restart) begin
			next_s.cnt = 16'h0000;
			next_s.ones = 16'h0000;
			next_s.since = 2'h0;
		end else if (lk.mod_tick) begin
			// [R21] count ticks up to ratio
			if (s.cnt >= last) begin
				// [R3] one word per period
				next_s.ready = 1'b1;
				next_s.word = s.ones + {15'h0000, s.sync2};
				next_s.cnt = 16'h0000;
				next_s.ones = 16'h0000;
				next_s.discard = (lk.mode == sdadc_pkg::SDADC_F_AUTO) && (s.since == 2'h0);
				// [R13] filter choice of this word
				if (lk.mode != sdadc_pkg::SDADC_F_AUTO) begin
					next_s.filt = lk.mode;
				// [R14] two fast conversions
				end else if (s.since < 2'(`SDADC_FAST_CONV)) begin
					next_s.filt = sdadc_pkg::SDADC_F_FAST;
				// [R15] then sinc2, then sinc3
				end else if (s.since == 2'(`SDADC_FAST_CONV)) begin
					next_s.filt = sdadc_pkg::SDADC_F_SINC2;
				end else begin
					next_s.filt = sdadc_pkg::SDADC_F_SINC3;
				end
				if (s.since != 2'h3) begin
					next_s.since = s.since + 2'h1;
				end
			end else begin
				next_s.cnt = s.cnt + 16'h0001;
				next_s.ones = s.ones + {15'h0000, s.sync2};
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign lk.ready = s.ready;
	assign lk.word = s.word;
	assign lk.filt = s.filt;
	assign lk.discard = s.discard;
endmodule

// *** core/sdadc_ctrl.sv ***
// Purpose: sigma-delta converter and string dac control registers
// Assumes: sfr port on the system clock, analog parts outside
// Notes: read data appears one clock after sfr_rd
// Function
// [R1] input buffer enabled or bypassed by setup register bit
// [R2] analog clock is system clock over divider plus one; modulator over 64
// [R3] one output word per decimation period of the high:low ratio
// [R4] gain stage selects gain 1 through 128 in powers of two
// [R5] offset trim is sign-magnitude: msb sign, seven bits magnitude
// [R6] trim applies only in bipolar mode, up to half full scale; trim outputs here are not gated by bipolar_mode
// [R7] writing calibration select starts that calibration
// [R8] each calibration step lasts seven conversions, combined fourteen
// [R9] outside input is zero for offset, full scale for gain calibration
// [R10] calibration end raises the converter flag
// [R11] software should calibrate after power-on and setting changes
// [R12] software should hold trim at zero during calibration
// [R13] filters: fast settling, sinc2, sinc3, or automatic
// [R14] automatic mode uses fast filter for two conversions, first discarded
// [R15] automatic mode then moves to sinc2 and then sinc3
// [R16] reference chosen in setup register; resets to internal 2.5 V
// [R17] internal reference level selectable as 1.25 V or 2.5 V
// [R18] software should disable unused internal reference
// [R19] dac code is 16-bit straight binary
// [R20] loaded dac code closes exactly one string tap
// [R21] decimation counts modulator ticks, data ready at ratio
`timescale 1ns/1ps
`include "sdadc_cfg.svh"
module sdadc_ctrl (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	output logic      [7:0]  sfr_rdata,
	input  wire logic        mod_bit,
	input  wire logic        channel_changed,
	output logic             input_buffer_enable,
	output logic             vref_enable,
	output logic             vref_level_high,
	output logic             vref_external,
	output logic      [2:0]  gain_stage,
	output logic      [7:0]  gain_factor,
	output logic             bipolar_mode,
	output logic             trim_negative,
	output logic      [6:0]  trim_magnitude,
	output logic             modulator_clock_tick,
	output logic      [1:0]  filter_active,
	output logic             cal_offset_phase,
	output logic             cal_gain_phase,
	output logic             cal_system_input,
	output logic             conversion_flag,
	output logic             data_ready,
	output logic      [15:0] data_word,
	output logic             discard_hint,
	output logic      [15:0] dac_tap,
	output logic             dac_tap_load
);
	logic                   rs1;
	logic                   rst_n;
	sdadc_pkg::sdadc_top_t  s;
	sdadc_pkg::sdadc_top_t  next_s;
	logic                   wr_setup;
	logic                   wr_cal;
	logic                   cal_done;
	sdadc_link_if           lk ();

	function automatic logic [7:0] gain_of(input logic [2:0] g);
		gain_of = 8'h01 << g;
	endfunction

	// reset release through two flops
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rs1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs1 <= 1'b1;
			rst_n <= rs1;
		end
	end

	assign lk.divisor = s.aclk;
	assign lk.ratio = s.dec;
	assign lk.mode = s.mode;
	assign lk.restart = s.restart;
	assign lk.mod_bit = mod_bit;

	sdadc_clkdiv u_div (
		.clock (clock),
		.rst_n (rst_n),
		.lk    (lk)
	);

	sdadc_decim u_dec (
		.clock (clock),
		.rst_n (rst_n),
		.lk    (lk)
	);

	assign wr_setup = sfr_wr && (sfr_addr == `SDADC_A_SETUP);
	assign wr_cal = sfr_wr && (sfr_addr == `SDADC_A_CAL);
	assign cal_done = (s.cal != sdadc_pkg::SDADC_CAL_IDLE) && s.ready
		&& (s.cal_cnt == 3'(`SDADC_CAL_STEP - 1));

	always_comb begin
		next_s = s;
		next_s.restart = 1'b0;
		next_s.dac_load = 1'b0;
		next_s.tick = lk.mod_tick;
		next_s.ready = lk.ready;
		next_s.word = lk.word;
		next_s.filt = lk.filt;
		next_s.discard = lk.discard;
		// [R14] channel change restarts the sequence
		if (channel_changed) begin
			next_s.restart = 1'b1;
		end
		if (sfr_wr) begin
			case (sfr_addr)
				`SDADC_A_SETUP: begin
					// [R1] [R16] [R17] buffer and reference bits
					next_s.setup = sfr_wdata;
					if (sfr_wdata[`SDADC_B_GAIN +: 3] != s.setup[`SDADC_B_GAIN +: 3]) begin
						next_s.restart = 1'b1;
					end
				end
				`SDADC_A_CAL: begin
					next_s.mode = sdadc_pkg::sdadc_filt_t'(sfr_wdata[`SDADC_B_FILT +: 2]);
					next_s.sel = sfr_wdata[2:0];
				end
				`SDADC_A_DEC_LO: begin
					next_s.dec[7:0] = sfr_wdata;
					next_s.restart = 1'b1;
				end
				`SDADC_A_DEC_HI: begin
					next_s.dec[15:8] = sfr_wdata;
					next_s.restart = 1'b1;
				end
				`SDADC_A_TRIM: next_s.trim = sfr_wdata;
				`SDADC_A_ACLK: next_s.aclk = sfr_wdata;
				`SDADC_A_DAC_LO: next_s.dac_lo = sfr_wdata;
				`SDADC_A_DAC_HI: begin
					// [R19] [R20] whole code loads at once
					next_s.dac = {sfr_wdata, s.dac_lo};
					next_s.dac_load = 1'b1;
				end
				default: ;
			endcase
		end
		// [R4] gain factor from gain stage code
		next_s.gain = gain_of(next_s.setup[`SDADC_B_GAIN +: 3]);
		// [R7] start on select write
		if (wr_cal) begin
			next_s.cal_cnt = 3'h0;
			next_s.restart = 1'b1;
			next_s.cal_sys = sfr_wdata[2];
			next_s.cal_both = (sfr_wdata[1:0] == 2'h3);
			case (sfr_wdata[1:0])
				2'h1: next_s.cal = sdadc_pkg::SDADC_CAL_OFFSET;
				2'h2: next_s.cal = sdadc_pkg::SDADC_CAL_GAIN;
				2'h3: next_s.cal = sdadc_pkg::SDADC_CAL_OFFSET;
				default: next_s.cal = sdadc_pkg::SDADC_CAL_IDLE;
			endcase
			if (sfr_wdata[2:0] == 3'h7) begin
				next_s.cal = sdadc_pkg::SDADC_CAL_IDLE;
			end
		end else if (s.cal != sdadc_pkg::SDADC_CAL_IDLE && s.ready) begin
			// [R8] seven conversions per step
			next_s.cal_cnt = s.cal_cnt + 3'h1;
			if (cal_done) begin
				next_s.cal_cnt = 3'h0;
				if (s.cal == sdadc_pkg::SDADC_CAL_OFFSET && s.cal_both) begin
					next_s.cal = sdadc_pkg::SDADC_CAL_GAIN;
				end else begin
					next_s.cal = sdadc_pkg::SDADC_CAL_IDLE;
					next_s.sel = 3'h0;
				end
			end
		end
		// [R10] flag set wins over write-one clear
		if (wr_cal && sfr_wdata[`SDADC_B_FLAG]) begin
			next_s.flag = 1'b0;
		end
		if ((cal_done && next_s.cal == sdadc_pkg::SDADC_CAL_IDLE)
			|| (s.ready && s.cal == sdadc_pkg::SDADC_CAL_IDLE)) begin
			next_s.flag = 1'b1;
		end
		next_s.rdata = s.rdata;
		if (sfr_rd) begin
			case (sfr_addr)
				`SDADC_A_SETUP: next_s.rdata = s.setup;
				`SDADC_A_CAL: next_s.rdata = {s.flag, s.discard,
					s.cal != sdadc_pkg::SDADC_CAL_IDLE, s.mode, s.sel};
				`SDADC_A_DEC_LO: next_s.rdata = s.dec[7:0];
				`SDADC_A_DEC_HI: next_s.rdata = s.dec[15:8];
				`SDADC_A_TRIM: next_s.rdata = s.trim;
				`SDADC_A_ACLK: next_s.rdata = s.aclk;
				`SDADC_A_DAC_LO: next_s.rdata = s.dac[7:0];
				`SDADC_A_DAC_HI: next_s.rdata = s.dac[15:8];
				default: next_s.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.setup <= `SDADC_R_SETUP;
			s.aclk <= `SDADC_R_ACLK;
			s.dec <= `SDADC_R_DEC;
			s.gain <= 8'h01;
		end else begin
			s <= next_s;
		end
	end

	assign sfr_rdata = s.rdata;
	assign input_buffer_enable = s.setup[`SDADC_B_BUF];
	assign vref_enable = s.setup[`SDADC_B_REF_EN];
	assign vref_level_high = s.setup[`SDADC_B_REF_HI];
	assign vref_external = s.setup[`SDADC_B_REF_EXT];
	assign gain_stage = s.setup[`SDADC_B_GAIN +: 3];
	assign gain_factor = s.gain;
	assign bipolar_mode = s.setup[`SDADC_B_BIPOLAR];
	// [R5] [R6] sign and magnitude, driven in every mode, not gated by bipolar_mode
	assign trim_negative = s.trim[7];
	assign trim_magnitude = s.trim[6:0];
	assign modulator_clock_tick = s.tick;
	assign filter_active = s.filt;
	assign cal_offset_phase = (s.cal == sdadc_pkg::SDADC_CAL_OFFSET);
	assign cal_gain_phase = (s.cal == sdadc_pkg::SDADC_CAL_GAIN);
	assign cal_system_input = s.cal_sys;
	assign conversion_flag = s.flag;
	assign data_ready = s.ready;
	assign data_word = s.word;
	assign discard_hint = s.discard;
	assign dac_tap = s.dac;
	assign dac_tap_load = s.dac_load;

	// checking helpers
	logic [21:0] gap;
	logic [16:0] ticks;
	logic        clean;
	logic [3:0]  convs;
	logic        steady;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			steady <= 1'b0;
			gap <= '0;
			ticks <= '0;
			clean <= 1'b0;
			convs <= '0;
		end else begin
			// divider setting unchanged over the whole tick period
			steady <= (lk.mod_tick || steady) && (s.aclk == next_s.aclk);
			gap <= lk.mod_tick ? 22'h00_0001 : gap + 22'h00_0001;
			ticks <= data_ready ? 17'(s.tick) : ticks + 17'(s.tick);
			clean <= s.restart ? 1'b0 : (data_ready ? 1'b1 : clean);
			convs <= wr_cal ? 4'h0 : convs + 4'(s.ready);
		end
	end

	a_buffer_follow: assert property (@(posedge clock) disable iff (!rst_n)
		wr_setup |=> input_buffer_enable == $past(sfr_wdata[`SDADC_B_BUF])) // [R1]
		else $error("buffer enable did not follow write");
	a_mod_period: assert property (@(posedge clock) disable iff (!rst_n)
		lk.mod_tick && steady
		|-> gap == 22'(({14'h0000, s.aclk} + 22'h1) * `SDADC_MOD_DIV)) // [R2]
		else $error("modulator tick period wrong");
	a_ready_ratio: assert property (@(posedge clock) disable iff (!rst_n)
		data_ready && clean && $stable(s.dec)
		|-> ticks == ((s.dec == 16'h0000) ? 17'h1 : {1'b0, s.dec})) // [R3]
		else $error("conversion period wrong");
	a_gain_map: assert property (@(posedge clock) disable iff (!rst_n)
		gain_factor == (8'h01 << gain_stage)) // [R4]
		else $error("gain factor mismatch");
	a_trim_sign: assert property (@(posedge clock) disable iff (!rst_n)
		sfr_wr && sfr_addr == `SDADC_A_TRIM
		|=> trim_negative == $past(sfr_wdata[7])) // [R5]
		else $error("trim sign wrong");
	a_cal_start: assert property (@(posedge clock) disable iff (!rst_n)
		wr_cal && sfr_wdata[1:0] != 2'h0 && sfr_wdata[2:0] != 3'h7
		|=> cal_offset_phase || cal_gain_phase) // [R7]
		else $error("calibration did not start");
	a_cal_length: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(cal_offset_phase || cal_gain_phase) && !$past(wr_cal)
		|-> convs == (s.cal_both ? 4'he : 4'h7)) // [R8]
		else $error("calibration length wrong");
	a_cal_flag: assert property (@(posedge clock) disable iff (!rst_n)
		cal_done && !s.cal_both |=> conversion_flag) // [R10]
		else $error("flag not raised at calibration end");
	a_auto_fast: assert property (@(posedge clock) disable iff (!rst_n)
		data_ready && discard_hint |-> filter_active == sdadc_pkg::SDADC_F_FAST) // [R14]
		else $error("first auto conversion not fast");
	a_ref_reset: assert property (@(posedge clock)
		$rose(rst_n) |-> vref_enable && vref_level_high && !vref_external) // [R16]
		else $error("reference reset state wrong");
	a_dac_hold: assert property (@(posedge clock) disable iff (!rst_n)
		$changed(dac_tap) |-> dac_tap_load) // [R20]
		else $error("dac tap moved without load");

	c_cal_both: cover property (@(posedge clock) disable iff (!rst_n)
		cal_gain_phase && s.cal_both ##1 !cal_gain_phase);
	c_auto_sinc3: cover property (@(posedge clock) disable iff (!rst_n)
		data_ready && filter_active == sdadc_pkg::SDADC_F_SINC3);
	c_dac_load: cover property (@(posedge clock) disable iff (!rst_n) dac_tap_load);
endmodule

// *** dv/sdadc_sensor.sv ***
// Purpose: sensor stand-in driving the modulator bitstream
// Assumes: the bit changes once per modulator tick
// Notes: alternating bits mean zero input, all ones mean full scale
`timescale 1ns/1ps
module sdadc_sensor (
	input  wire logic clock,
	input  wire logic tick,
	input  wire logic offset_phase,
	input  wire logic gain_phase,
	input  wire logic system_input,
	input  wire logic full_scale,
	output logic      mod_bit
);
	initial mod_bit = 1'b0;
	// zero or full scale in system calibration
	always @(posedge clock) begin
		if (tick) begin
			if (system_input && gain_phase)
				mod_bit <= 1'b1;
			else if (system_input && offset_phase)
				mod_bit <= ~mod_bit;
			else
				mod_bit <= full_scale | ~mod_bit;
		end
	end
endmodule

// *** dv/sigma_delta_adc_control_bench.sv ***
// Purpose: self-checking bench of the converter control
// Assumes: inputs driven at the falling edge
// Notes: analog clock divider set to zero for short ticks
`timescale 1ns/1ps
module sigma_delta_adc_control_bench;
	typedef struct {
		logic [7:0]  addr;
		logic [7:0]  data;
		logic [23:0] exp_out;
		logic [7:0]  exp_rd;
	} sdadc_row_t;
	logic        clock, reset_n, sfr_wr, sfr_rd, mod_bit, channel_changed, full_scale;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, gain_factor, v;
	logic        input_buffer_enable, vref_enable, vref_level_high, vref_external;
	logic        bipolar_mode, trim_negative, modulator_clock_tick, cal_offset_phase;
	logic        cal_gain_phase, cal_system_input, conversion_flag, data_ready;
	logic        discard_hint, dac_tap_load;
	logic [2:0]  gain_stage, seen;
	logic [6:0]  trim_magnitude;
	logic [1:0]  filter_active;
	logic [15:0] data_word, dac_tap;
	int          fails, n_checks, cycles, n, k, cnt;
	sdadc_row_t  rows [12] = '{
		'{8'hdc, 8'h01, 24'h00_0011, 8'h01}, '{8'hdc, 8'h12, 24'h00_1022, 8'h12},
		'{8'hdc, 8'h24, 24'h00_2044, 8'h24}, '{8'hdc, 8'h38, 24'h00_3088, 8'h38},
		'{8'hdc, 8'h46, 24'h00_4106, 8'h46}, '{8'hdc, 8'h5f, 24'h00_520f, 8'h5f},
		'{8'hdc, 8'h60, 24'h00_6400, 8'h60}, '{8'hdc, 8'hf3, 24'h00_f803, 8'hf3},
		'{8'he6, 8'h85, 24'h85_f803, 8'h85}, '{8'he6, 8'h7f, 24'h7f_f803, 8'h7f},
		'{8'hd0, 8'hff, 24'h7f_f803, 8'h00}, '{8'hf6, 8'h00, 24'h7f_f803, 8'h00}};
	logic [15:0] rst_tab [5] = '{16'hdc06, 16'hf603, 16'hde00, 16'hdf01, 16'he600};
	logic [7:0]  aclk_tab [2] = '{8'h01, 8'h00};
	logic [2:0]  auto_exp [4] = '{3'h3, 3'h2, 3'h4, 3'h6};
	logic [2:0]  cal_sel [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
	logic [2:0]  cal_seen [5] = '{3'h4, 3'h2, 3'h6, 3'h5, 3'h3};
	int          cal_len [5] = '{7, 7, 14, 7, 7};

	sdadc_ctrl i_sdadc_ctrl (
		.clock, .reset_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .mod_bit,
		.channel_changed, .input_buffer_enable, .vref_enable, .vref_level_high,
		.vref_external, .gain_stage, .gain_factor, .bipolar_mode, .trim_negative,
		.trim_magnitude, .modulator_clock_tick, .filter_active, .cal_offset_phase,
		.cal_gain_phase, .cal_system_input, .conversion_flag, .data_ready, .data_word,
		.discard_hint, .dac_tap, .dac_tap_load
	);
	sdadc_sensor i_sdadc_sensor (
		.clock, .tick(modulator_clock_tick), .offset_phase(cal_offset_phase),
		.gain_phase(cal_gain_phase), .system_input(cal_system_input), .full_scale, .mod_bit
	);

	always #25 clock = ~clock;

	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			complete_run();
		end
	end

	task check_value(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clock);
		sfr_wr = 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clock);
		sfr_rd = 1'b0;
		@(negedge clock);
		d = sfr_rdata;
	endtask

	task wait_sig(input bit r, output int c);
		c = 0;
		do begin
			@(negedge clock);
			c++;
		end while ((r ? data_ready : modulator_clock_tick) !== 1'b1 && c < 5000);
	endtask

	function automatic logic [23:0] obs();
		return {trim_negative, trim_magnitude, bipolar_mode, gain_stage, gain_factor,
			vref_external, vref_level_high, vref_enable, input_buffer_enable};
	endfunction

	task do_reset;
		reset_n = 1'b0;
		repeat (12) @(negedge clock);
		reset_n = 1'b1;
		repeat (4) @(negedge clock);
		check_value("reset outputs", 24'h00_0016, obs());
		check_value("reset status", 24'h00_0000, {conversion_flag, cal_offset_phase,
			cal_gain_phase, cal_system_input, filter_active, data_ready, discard_hint,
			dac_tap});
		foreach (rst_tab[i]) begin
			rd(rst_tab[i][15:8], v);
			check_value("reset read", {16'h0000, rst_tab[i][7:0]}, {16'h0000, v});
		end
		$display("test reset done");
	endtask

	initial begin
		clock = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		channel_changed = 1'b0;
		full_scale = 1'b0;
		do_reset();
		// register rows; the external reference row 8'h38 drops the internal one, 8'h5f keeps it
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].data);
			@(negedge clock);
			check_value("port outputs", rows[i].exp_out, obs());
			rd(rows[i].addr, v);
			check_value("read back", {16'h0000, rows[i].exp_rd}, {16'h0000, v});
		end
		$display("test registers done");
		foreach (aclk_tab[i]) begin
			wr(8'hf6, aclk_tab[i]);
			repeat (3) wait_sig(0, n);
			check_value("tick spacing", 24'((aclk_tab[i] + 1) * 64), 24'(n));
		end
		$display("test clocks done");
		wr(8'hdf, 8'h00);
		wr(8'hde, 8'h04);
		repeat (3) wait_sig(1, n);
		check_value("word spacing", 24'h00_0100, 24'(n));
		check_value("ones count", 24'h00_0002, {8'h00, data_word});
		full_scale = 1'b1;
		repeat (2) wait_sig(1, n);
		check_value("ones count", 24'h00_0004, {8'h00, data_word});
		full_scale = 1'b0;
		$display("test decimation done");
		for (int m = 1; m < 4; m++) begin
			wr(8'hdd, {3'h0, m[1:0], 3'h0});
			repeat (2) wait_sig(1, n);
			check_value("fixed filter", 24'(m), {22'h0, filter_active});
		end
		wr(8'hdd, 8'h00);
		wait_sig(1, n);
		channel_changed = 1'b1;
		@(negedge clock);
		channel_changed = 1'b0;
		for (int w = 0; w < 4; w++) begin
			wait_sig(1, n);
			check_value("auto filter", {21'h0, auto_exp[w]}, {21'h0, filter_active, discard_hint});
		end
		wr(8'hdc, 8'h06);
		wait_sig(1, n);
		check_value("gain restart", 24'h00_0003, {21'h0, filter_active, discard_hint});
		$display("test filters done");
		wr(8'he6, 8'h00);
		foreach (cal_sel[i]) begin
			wr(8'hdd, {5'h10, cal_sel[i]});
			@(negedge clock);
			seen = 3'h0;
			cnt = 0;
			k = 0;
			while (conversion_flag !== 1'b1 && k < 20000) begin
				@(negedge clock);
				seen = seen | {cal_offset_phase, cal_gain_phase, cal_system_input};
				if (data_ready === 1'b1)
					cnt++;
				k++;
			end
			check_value("cal length", 24'(cal_len[i]), 24'(cnt));
			check_value("cal phases", {21'h0, cal_seen[i]}, {21'h0, seen});
			if (cal_sel[i] === 3'h6)
				check_value("gain cal word", 24'h00_0004, {8'h00, data_word});
			rd(8'hdd, v);
			check_value("select cleared", 24'h00_0000, {21'h0, v[2:0]});
		end
		wr(8'hdd, 8'h80);
		wait_sig(1, n);
		@(negedge clock);
		check_value("flag on data", 24'h00_0001, {23'h0, conversion_flag});
		$display("test calibration done");
		foreach (rst_tab[i]) begin
			wr(8'he8, 8'(16'h5aa5 ^ (16'h1111 * i)));
			wr(8'he9, 8'((16'h5aa5 ^ (16'h1111 * i)) >> 8));
			k = 0;
			while (dac_tap_load !== 1'b1 && k < 3) begin
				@(negedge clock);
				k++;
			end
			check_value("dac tap", {8'h00, 16'h5aa5 ^ 16'(16'h1111 * i)}, {8'h00, dac_tap});
			check_value("dac load", 24'h00_0001, {23'h0, dac_tap_load});
		end
		$display("test dac done");
		do_reset();
		complete_run();
	end
endmodule
